/* File: hw/ptc_homing.sv */
// homing controller: register port, input sync, sequencer, counters
// assumes sensors arrive asynchronously and run mode is on the core clock
`timescale 1ns/1ps
`default_nettype none
module ptc_homing #(
	parameter int          NUM_CH  = 4,
	parameter logic [17:0] DEC_STEP = 18'h00064
) (
	input  wire logic        i_core_clk,
	input  wire logic        i_rst,
	input  wire logic        i_ce,
	input  wire logic        i_run_mode,
	input  wire logic        i_near_point_sensor,
	input  wire logic        i_zero_phase,
	input  wire logic        i_reverse_limit,
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata,
	output logic      [3:0]  o_pulse,
	output logic      [3:0]  o_busy,
	output logic      [3:0]  o_clear,
	output logic      [3:0]  o_clear_alt
);
	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic [2:0] sync_a_r, sync_b_r, sync_c_r, filt_r, filt_d_r, filt_nxt;
	logic       near_rise, near_fall, zero_rise, rlim_rise;

	always_comb begin
		for (int i = 0; i < 3; i++) begin
			filt_nxt[i] = (sync_b_r[i] == sync_c_r[i]) ? sync_c_r[i] : filt_r[i];
		end
	end
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			sync_a_r <= 3'h0;
			sync_b_r <= 3'h0;
			sync_c_r <= 3'h0;
			filt_r   <= 3'h0;
			filt_d_r <= 3'h0;
		end else if (i_ce) begin
			sync_a_r <= {i_reverse_limit, i_zero_phase, i_near_point_sensor};
			sync_b_r <= sync_a_r;
			sync_c_r <= sync_b_r;
			filt_r   <= filt_nxt;
			filt_d_r <= filt_r;
		end
	end
	assign near_rise = filt_r[0] & ~filt_d_r[0];
	assign near_fall = ~filt_r[0] & filt_d_r[0];
	assign zero_rise = filt_r[1] & ~filt_d_r[1];
	assign rlim_rise = filt_r[2] & ~filt_d_r[2];

	// ----------------------------------------
	// registers and sequencer
	// ----------------------------------------
	ptc_gen_if gif ();
	ptc_pulse_gen u_gen (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_ce       (i_ce),
		.gen        (gif)
	);

	ptc_pkg::ptc_state_t st_r, st_nxt;
	logic [11:0] ctrl_r, ctrl_nxt;
	logic        run_r, run_nxt;
	logic [1:0]  ch_r, ch_nxt, act_r, act_nxt;
	logic [17:0] rspd_r, rspd_nxt, cspd_r, cspd_nxt;
	logic [17:0] spd_r, spd_nxt, creep_r, creep_nxt;
	logic [5:0]  tick_r, tick_nxt;
	logic [9:0]  clr_cnt_r, clr_cnt_nxt;
	logic        done_r, done_nxt, abort_r, abort_nxt, habt_r, habt_nxt;
	logic [31:0] rdata_nxt;
	logic [3:0]  busy_nxt, pulse_nxt, clr_nxt, clr_alt_nxt;
	logic        start, tick, zero_pos;
	logic [31:0] pos_r [NUM_CH];

	assign tick = (tick_r == 6'(ptc_pkg::DEC_TICK_CYC - 1));
	// a new command waits for the activation edge; one generator means one busy channel
	assign start = run_nxt & ~run_r & (st_r == ptc_pkg::ST_IDLE) & i_run_mode
		& (32'(ch_nxt) < 32'(NUM_CH));

	always_comb begin
		ctrl_nxt    = ctrl_r;
		run_nxt     = run_r;
		ch_nxt      = ch_r;
		rspd_nxt    = rspd_r;
		cspd_nxt    = cspd_r;
		st_nxt      = st_r;
		act_nxt     = act_r;
		spd_nxt     = spd_r;
		creep_nxt   = creep_r;
		tick_nxt    = (st_r == ptc_pkg::ST_IDLE || tick) ? 6'h00 : tick_r + 6'h01;
		clr_cnt_nxt = clr_cnt_r;
		done_nxt    = done_r;
		abort_nxt   = abort_r;
		habt_nxt    = habt_r;
		zero_pos    = 1'b0;
		if (i_wr) begin
			case (i_addr)
				ptc_pkg::ADDR_CTRL: ctrl_nxt = i_wdata[11:0];
				ptc_pkg::ADDR_CMD: begin
					run_nxt = i_wdata[ptc_pkg::CMD_RUN_BIT];
					ch_nxt  = i_wdata[ptc_pkg::CMD_CH_LSB +: 2];
				end
				ptc_pkg::ADDR_RSPD: rspd_nxt = i_wdata[17:0];
				ptc_pkg::ADDR_CSPD: cspd_nxt = i_wdata[17:0];
				default: ;
			endcase
		end
		if (!i_run_mode) begin
			ctrl_nxt = ptc_pkg::CTRL_RST;
		end
		if (!run_nxt) begin
			done_nxt = 1'b0;
		end
		case (st_r)
			ptc_pkg::ST_IDLE: begin
				if (start) begin
					// operands are latched, later changes have no effect
					st_nxt    = ptc_pkg::ST_FAST;
					act_nxt   = ch_nxt;
					spd_nxt   = rspd_r;
					creep_nxt = cspd_r;
					abort_nxt = 1'b0;
					done_nxt  = 1'b0;
				end
			end
			ptc_pkg::ST_FAST: begin
				if (near_rise) begin
					st_nxt = ptc_pkg::ST_DECEL;
				end else if (rlim_rise) begin
					st_nxt   = ptc_pkg::ST_HALT;
					habt_nxt = 1'b1;
				end
			end
			ptc_pkg::ST_DECEL: begin
				if (near_fall) begin
					st_nxt = ptc_pkg::ST_ZSEEK;
				end else if (spd_r <= creep_r) begin
					spd_nxt = creep_r;
					st_nxt  = ptc_pkg::ST_CREEP;
				end else if (tick) begin
					spd_nxt = (spd_r > creep_r + DEC_STEP) ? spd_r - DEC_STEP : creep_r;
				end
			end
			ptc_pkg::ST_CREEP: begin
				if (near_fall) begin
					st_nxt = ptc_pkg::ST_ZSEEK;
				end
			end
			ptc_pkg::ST_ZSEEK: begin
				if (zero_rise) begin
					zero_pos    = 1'b1;
					clr_cnt_nxt = 10'h000;
					if (ctrl_r[ptc_pkg::CTRL_CLR_EN_LSB + 32'(act_r)]) begin
						st_nxt = ptc_pkg::ST_CLEAR;
					end else begin
						st_nxt   = ptc_pkg::ST_IDLE;
						done_nxt = 1'b1;
					end
				end
			end
			ptc_pkg::ST_CLEAR: begin
				clr_cnt_nxt = clr_cnt_r + 10'h001;
				if (clr_cnt_r == 10'(ptc_pkg::CLEAR_CYC - 1)) begin
					st_nxt   = ptc_pkg::ST_IDLE;
					done_nxt = 1'b1;
				end
			end
			ptc_pkg::ST_HALT: begin
				if (spd_r <= ptc_pkg::SPD_MIN_HZ + DEC_STEP) begin
					st_nxt    = ptc_pkg::ST_IDLE;
					abort_nxt = habt_r;
					habt_nxt  = 1'b0;
				end else if (tick) begin
					spd_nxt = spd_r - DEC_STEP;
				end
			end
			default: st_nxt = ptc_pkg::ST_IDLE;
		endcase
		// activation drop or leaving run mode outside CLEAR: slow down, no done
		if (st_r != ptc_pkg::ST_IDLE && st_r != ptc_pkg::ST_HALT
				&& st_r != ptc_pkg::ST_CLEAR && (!run_r || !i_run_mode)) begin
			st_nxt   = ptc_pkg::ST_HALT;
			done_nxt = 1'b0;
		end
		// a completion seen while the activation is already low never counts
		if (!run_r) begin
			done_nxt = 1'b0;
		end
		if (st_r != ptc_pkg::ST_IDLE && ctrl_r[ptc_pkg::CTRL_STOP_LSB + 32'(act_r)]) begin
			st_nxt   = ptc_pkg::ST_IDLE;
			habt_nxt = 1'b0;
			done_nxt = 1'b0;
		end
	end

	assign gif.en    = (st_r != ptc_pkg::ST_IDLE) && (st_r != ptc_pkg::ST_CLEAR);
	assign gif.speed = spd_r;

	// ----------------------------------------
	// per-channel position counters
	// ----------------------------------------
	generate
		for (genvar c = 0; c < NUM_CH; c++) begin : g_pos
			logic [31:0] pos_nxt;
			logic        mine;
			assign mine = (32'(act_r) == c);
			always_comb begin
				pos_nxt = pos_r[c];
				if (mine && zero_pos) begin
					pos_nxt = 32'h00000000;
				end else if (mine && gif.step && gif.en) begin
					pos_nxt = pos_r[c] - 32'h00000001;
				end
			end
			always_ff @(posedge i_core_clk or posedge i_rst) begin
				if (i_rst) begin
					pos_r[c] <= 32'h00000000;
				end else if (i_ce) begin
					pos_r[c] <= pos_nxt;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// outputs and read data
	// ----------------------------------------
	always_comb begin
		busy_nxt    = 4'h0;
		pulse_nxt   = 4'h0;
		clr_nxt     = 4'h0;
		clr_alt_nxt = 4'h0;
		rdata_nxt   = 32'h00000000;
		if (st_nxt != ptc_pkg::ST_IDLE) begin
			busy_nxt[act_nxt] = 1'b1;
		end
		pulse_nxt[act_r] = gif.step & gif.en;
		if (st_nxt == ptc_pkg::ST_CLEAR) begin
			// alternate pin only when its select bit is set
			if (ctrl_r[ptc_pkg::CTRL_SEL_LSB + 32'(act_nxt)]) begin
				clr_alt_nxt[act_nxt] = 1'b1;
			end else begin
				clr_nxt[act_nxt] = 1'b1;
			end
		end
		if (i_rd) begin
			case (i_addr)
				ptc_pkg::ADDR_CTRL: rdata_nxt = {20'h00000, ctrl_r};
				ptc_pkg::ADDR_CMD:  rdata_nxt = {26'h0000000, ch_r, 3'h0, run_r};
				ptc_pkg::ADDR_STAT: rdata_nxt = {24'h000000, o_busy, 2'h0, abort_r, done_r};
				ptc_pkg::ADDR_RSPD: rdata_nxt = {14'h0000, rspd_r};
				ptc_pkg::ADDR_CSPD: rdata_nxt = {14'h0000, cspd_r};
				default: begin
					for (int c = 0; c < NUM_CH; c++) begin
						if (i_addr == ptc_pkg::ADDR_POS0 + 8'(c * 4)) begin
							rdata_nxt = pos_r[c];
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			st_r        <= ptc_pkg::ST_IDLE;
			ctrl_r      <= ptc_pkg::CTRL_RST;
			run_r       <= 1'b0;
			ch_r        <= 2'h0;
			act_r       <= 2'h0;
			rspd_r      <= ptc_pkg::RSPD_RST;
			cspd_r      <= ptc_pkg::CSPD_RST;
			spd_r       <= 18'h00000;
			creep_r     <= 18'h00000;
			tick_r      <= 6'h00;
			clr_cnt_r   <= 10'h000;
			done_r      <= 1'b0;
			abort_r     <= 1'b0;
			habt_r      <= 1'b0;
			o_rdata     <= 32'h00000000;
			o_pulse     <= 4'h0;
			o_busy      <= 4'h0;
			o_clear     <= 4'h0;
			o_clear_alt <= 4'h0;
		end else if (i_ce) begin
			st_r        <= st_nxt;
			ctrl_r      <= ctrl_nxt;
			run_r       <= run_nxt;
			ch_r        <= ch_nxt;
			act_r       <= act_nxt;
			rspd_r      <= rspd_nxt;
			cspd_r      <= cspd_nxt;
			spd_r       <= spd_nxt;
			creep_r     <= creep_nxt;
			tick_r      <= tick_nxt;
			clr_cnt_r   <= clr_cnt_nxt;
			done_r      <= done_nxt;
			abort_r     <= abort_nxt;
			habt_r      <= habt_nxt;
			o_rdata     <= rdata_nxt;
			o_pulse     <= pulse_nxt;
			o_busy      <= busy_nxt;
			o_clear     <= clr_nxt;
			o_clear_alt <= clr_alt_nxt;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	sequence s_seek_hit;
		st_r == ptc_pkg::ST_ZSEEK && zero_rise && i_ce;
	endsequence
	property p_ctrl_drop;
		@(posedge i_core_clk) disable iff (i_rst) (!i_run_mode && i_ce) |=> ctrl_r == 12'h000;
	endproperty
	a_ctrl_drop: assert property (p_ctrl_drop) else $error("ctrl bits survive stop mode");
	property p_done_src;
		@(posedge i_core_clk) disable iff (i_rst) $rose(done_r) |->
			$past(st_r) == ptc_pkg::ST_ZSEEK || $past(st_r) == ptc_pkg::ST_CLEAR;
	endproperty
	a_done_src: assert property (p_done_src) else $error("done set outside completion");
	property p_pos_zero;
		@(posedge i_core_clk) disable iff (i_rst) s_seek_hit |=> pos_r[act_r] == 32'h00000000;
	endproperty
	a_pos_zero: assert property (p_pos_zero) else $error("position not cleared");
	property p_limit_abort;
		@(posedge i_core_clk) disable iff (i_rst)
			(st_r == ptc_pkg::ST_FAST && rlim_rise && !near_rise && run_r && i_run_mode && i_ce
			&& !ctrl_r[ptc_pkg::CTRL_STOP_LSB + 32'(act_r)]) |=> habt_r && st_r == ptc_pkg::ST_HALT;
	endproperty
	a_limit_abort: assert property (p_limit_abort) else $error("limit did not abort");
	property p_drop_nodone;
		@(posedge i_core_clk) disable iff (i_rst) (!run_r && i_ce) |=> !done_r;
	endproperty
	a_drop_nodone: assert property (p_drop_nodone) else $error("done while inactive");
	property p_decel_src;
		@(posedge i_core_clk) disable iff (i_rst) $rose(st_r == ptc_pkg::ST_DECEL) |-> $past(near_rise);
	endproperty
	a_decel_src: assert property (p_decel_src) else $error("decel without near point");
	property p_busy;
		@(posedge i_core_clk) disable iff (i_rst) st_r != ptc_pkg::ST_IDLE |-> o_busy[act_r];
	endproperty
	a_busy: assert property (p_busy) else $error("busy low while homing");
	property p_stop;
		@(posedge i_core_clk) disable iff (i_rst)
			(st_r != ptc_pkg::ST_IDLE && ctrl_r[ptc_pkg::CTRL_STOP_LSB + 32'(act_r)] && i_ce)
			|=> st_r == ptc_pkg::ST_IDLE ##1 o_pulse == 4'h0;
	endproperty
	a_stop: assert property (p_stop) else $error("stop did not halt");
	property p_clear;
		@(posedge i_core_clk) disable iff (i_rst) st_r == ptc_pkg::ST_CLEAR |-> (o_clear | o_clear_alt) != 4'h0;
	endproperty
	a_clear: assert property (p_clear) else $error("clear output missing");
endmodule // ptc_homing
`default_nettype wire

/* File: hw/ptc_pkg.sv */
// constants shared by the homing controller and its pulse generator
// assumes a single 40 MHz core clock and byte register offsets
// What this block does
// - shared done and abort flags, read only
// - per-channel busy monitor bit, read only
// - per-channel enable asserts CLEAR after homing
// - per-channel bit selects alternate CLEAR output
// - per-channel stop bit halts pulse output
// - leaving run mode clears those control bits
// - slow at near-point rise, stop at zero-phase
// - homing completion zeroes channel position counter
// - near point never found: stop, set abort
// - activation drop decelerates, stops, no done
package ptc_pkg;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] ADDR_CTRL  = 8'h00;
	localparam logic [7:0] ADDR_CMD   = 8'h04;
	localparam logic [7:0] ADDR_STAT  = 8'h08;
	localparam logic [7:0] ADDR_RSPD  = 8'h0C;
	localparam logic [7:0] ADDR_CSPD  = 8'h10;
	localparam logic [7:0] ADDR_POS0  = 8'h20;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CTRL_CLR_EN_LSB = 0;
	localparam int CTRL_SEL_LSB    = 4;
	localparam int CTRL_STOP_LSB   = 8;
	localparam int CMD_RUN_BIT     = 0;
	localparam int CMD_CH_LSB      = 4;
	localparam int STAT_DONE_BIT   = 0;
	localparam int STAT_ABORT_BIT  = 1;
	localparam int STAT_BUSY_LSB   = 4;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [11:0] CTRL_RST = 12'h000;
	localparam logic [17:0] RSPD_RST = 18'h003E8;
	localparam logic [17:0] CSPD_RST = 18'h00064;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_HZ        = 40000000;
	localparam int CLK_PERIOD_NS = 25;
	localparam int DEC_TICK_NS   = 1000;
	localparam int DEC_TICK_CYC  = (DEC_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CLEAR_NS      = 20000;
	localparam int CLEAR_CYC     = (CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [17:0] SPD_MIN_HZ = 18'h0000A;
	// ----------------------------------------
	// homing sequence states
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_FAST  = 3'h1,
		ST_DECEL = 3'h2,
		ST_CREEP = 3'h3,
		ST_ZSEEK = 3'h4,
		ST_CLEAR = 3'h5,
		ST_HALT  = 3'h6
	} ptc_state_t;
endpackage

/* File: hw/ptc_gen_if.sv */
// rate link between the homing sequencer and its pulse generator
// assumes both ends share the core clock
`timescale 1ns/1ps
`default_nettype none
interface ptc_gen_if;
	logic        en;
	logic [17:0] speed;
	logic        step;
	modport ctrl (output en, output speed, input step);
	modport gen  (input en, input speed, output step);
endinterface
`default_nettype wire

/* File: hw/ptc_pulse_gen.sv */
// phase-accumulator pulse generator: one step per 1/speed seconds
// assumes speed in Hz below half the core clock
`timescale 1ns/1ps
`default_nettype none
module ptc_pulse_gen (
	input  wire logic i_core_clk,
	input  wire logic i_rst,
	input  wire logic i_ce,
	ptc_gen_if.gen    gen
);
	logic [26:0] acc_r;
	logic [26:0] acc_nxt;
	logic        step_r;
	logic        step_nxt;
	logic [26:0] sum;

	always_comb begin
		sum      = acc_r + {9'h000, gen.speed};
		acc_nxt  = sum;
		step_nxt = 1'b0;
		if (!gen.en) begin
			acc_nxt = 27'h0000000;
		end else if (sum >= 27'(ptc_pkg::CLK_HZ)) begin
			acc_nxt  = sum - 27'(ptc_pkg::CLK_HZ);
			step_nxt = 1'b1;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			acc_r  <= 27'h0000000;
			step_r <= 1'b0;
		end else if (i_ce) begin
			acc_r  <= acc_nxt;
			step_r <= step_nxt;
		end
	end

	assign gen.step = step_r;
endmodule // ptc_pulse_gen
`default_nettype wire

/* File: verification/ptc_servo_model.sv */
// far-side model: amplifier with encoder zero phase and a near-point cam on the axis
// assumes one homing at a time; travel is counted in pulses from the start of each run
`timescale 1ns/1ps
`default_nettype none
module ptc_servo_model #(
	parameter int NEAR_ON  = 5,
	parameter int NEAR_OFF = 10,
	parameter int ZP_EVERY = 4
) (
	input  wire logic       i_core_clk,
	input  wire logic       i_rst,
	input  wire logic [3:0] i_pulse,
	input  wire logic [3:0] i_busy,
	input  wire logic       i_near_en,
	output logic            o_near_point_sensor,
	output logic            o_zero_phase
);
	int count;
	int zp_hold;
	// ----------------------------------------
	// axis travel and encoder
	// ----------------------------------------
	// one travel count for whichever channel is the single active one
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			count   <= 0;
			zp_hold <= 0;
		end else begin
			if (i_busy == 4'h0)
				count <= 0;
			else if (|i_pulse)
				count <= count + 1;
			// zero phase held 8 cycles so it survives the input synchroniser
			if (|i_pulse && ((count + 1) % ZP_EVERY == 0))
				zp_hold <= 8;
			else if (zp_hold != 0)
				zp_hold <= zp_hold - 1;
		end
	end
	// one near-point input, cam spans a fixed stretch of travel
	assign o_near_point_sensor = i_near_en && count >= NEAR_ON && count < NEAR_OFF;
	assign o_zero_phase        = zp_hold != 0;
endmodule // ptc_servo_model
`default_nettype wire

/* File: verification/test_pulse_train_homing_control.sv */
// self-checking bench for the homing controller with the servo model attached
// assumes the register map and timing of the package; decel step enlarged to keep runs short
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
	$display("unexpected at %0t: got %h exp %h", $time, (a), (b)); end end
module test_pulse_train_homing_control;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        ce = 1'b1;
	logic        run_mode = 1'b1;
	logic        rev_lim = 1'b0;
	logic        near_en = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [31:0] rdata;
	logic [3:0]  pulse, busy, clr, clr_alt, clr_seen, alt_seen;
	wire         near, zph;
	logic [31:0] d;
	int          fails = 0, n_tests = 0, npulse, gap, since;
	int          cur_ch;

	always #12.5 clk = ~clk;

	ptc_homing #(.NUM_CH(4), .DEC_STEP(18'h02710)) dut (
		.i_core_clk(clk), .i_rst(rst), .i_ce(ce), .i_run_mode(run_mode),
		.i_near_point_sensor(near), .i_zero_phase(zph), .i_reverse_limit(rev_lim),
		.i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
		.o_pulse(pulse), .o_busy(busy), .o_clear(clr), .o_clear_alt(clr_alt));
	ptc_servo_model srv (
		.i_core_clk(clk), .i_rst(rst), .i_pulse(pulse), .i_busy(busy),
		.i_near_en(near_en), .o_near_point_sensor(near), .o_zero_phase(zph));

	// ----------------------------------------
	// observers
	// ----------------------------------------
	always @(posedge clk) begin
		since++;
		if (pulse[cur_ch]) begin
			npulse++;
			gap   = since;
			since = 0;
		end
		clr_seen = clr_seen | clr;
		alt_seen = alt_seen | clr_alt;
	end

	// ----------------------------------------
	// access tasks
	// ----------------------------------------
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic wrr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rdr(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		rd   <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic wait_busy(input int ch, input logic v);
		int k;
		for (k = 0; k < 20000 && busy[ch] !== v; k++) begin
			@(posedge clk);
			#1;
		end
		if (busy[ch] !== v) begin
			fails++;
			summarize();
		end
	endtask
	task automatic wait_pulses(input int n);
		int k;
		for (k = 0; k < 20000 && npulse < n; k++)
			@(posedge clk);
		if (npulse < n) begin
			fails++;
			summarize();
		end
	endtask
	task automatic wait_stat(input int bitn);
		int k;
		d = 32'h0;
		for (k = 0; k < 12000 && d[bitn] !== 1'b1; k++)
			rdr(ptc_pkg::ADDR_STAT, d);
		if (d[bitn] !== 1'b1) begin
			fails++;
			summarize();
		end
	endtask
	task automatic start(input int ch);
		cur_ch   = ch;
		npulse   = 0;
		clr_seen = 4'h0;
		alt_seen = 4'h0;
		wrr(ptc_pkg::ADDR_CMD, (32'(ch) << 4) | 32'h1);
		wait_busy(ch, 1'b1);
	endtask
	// full homing run; sel picks the alternate clear output
	task automatic home(input int ch, input logic sel);
		wrr(ptc_pkg::ADDR_CTRL, (32'h1 << ch) | (32'(sel) << (4 + ch)));
		start(ch);
		wait_pulses(3);
		rdr(ptc_pkg::ADDR_POS0 + 8'(4 * ch), d);
		`CHK(d, 32'(0 - npulse))
		wait_stat(0);
		`CHK(d[1:0], 2'h1)
		`CHK(npulse > 10, 1'b1)
		`CHK(gap > 1500, 1'b1)
		rdr(ptc_pkg::ADDR_POS0 + 8'(4 * ch), d);
		`CHK(d, 32'h0)
		`CHK(clr_seen[ch], ~sel)
		`CHK(alt_seen[ch], sel)
		wrr(ptc_pkg::ADDR_CMD, 32'h0);
		rdr(ptc_pkg::ADDR_STAT, d);
		`CHK(d[0], 1'b0)
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		cur_ch = 0;
		since  = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rdr(ptc_pkg::ADDR_CTRL, d);
		`CHK(d, 32'h0)
		rdr(ptc_pkg::ADDR_RSPD, d);
		`CHK(d, 32'h000003E8)
		rdr(ptc_pkg::ADDR_CSPD, d);
		`CHK(d, 32'h00000064)
		wrr(ptc_pkg::ADDR_STAT, 32'h000000FF);
		rdr(ptc_pkg::ADDR_STAT, d);
		`CHK(d, 32'h0)
		rdr(8'h40, d);
		`CHK(d, 32'h0)
		// speeds kept inside the documented ranges
		wrr(ptc_pkg::ADDR_RSPD, 32'h000186A0);
		wrr(ptc_pkg::ADDR_CSPD, 32'h00004E20);
		rdr(ptc_pkg::ADDR_RSPD, d);
		`CHK(d, 32'h000186A0)
		home(1, 1'b0);
		home(3, 1'b1);
		// stop command on the active channel
		start(2);
		wrr(ptc_pkg::ADDR_CTRL, 32'h00000400);
		// the stop bit is seen one edge after the write lands
		@(posedge clk);
		#1 `CHK(busy[2], 1'b0)
		rdr(ptc_pkg::ADDR_STAT, d);
		`CHK(d[1:0], 2'h0)
		wrr(ptc_pkg::ADDR_CMD, 32'h0);
		wrr(ptc_pkg::ADDR_CTRL, 32'h0);
		// activation dropped mid-run, then a start tried while still ramping down
		start(0);
		wait_pulses(2);
		wrr(ptc_pkg::ADDR_CMD, 32'h0);
		wrr(ptc_pkg::ADDR_CMD, 32'h00000011);
		#1 `CHK(busy, 4'h1)
		wait_busy(0, 1'b0);
		`CHK(busy, 4'h0)
		rdr(ptc_pkg::ADDR_STAT, d);
		`CHK(d[1:0], 2'h0)
		wrr(ptc_pkg::ADDR_CMD, 32'h0);
		// near point never found: limit reached during the search
		near_en <= 1'b0;
		start(0);
		wait_pulses(2);
		@(posedge clk);
		rev_lim <= 1'b1;
		repeat (8) @(posedge clk);
		rev_lim <= 1'b0;
		wait_stat(1);
		`CHK(d[0], 1'b0)
		wait_busy(0, 1'b0);
		wrr(ptc_pkg::ADDR_CMD, 32'h0);
		near_en <= 1'b1;
		// leaving run mode clears the control bits
		wrr(ptc_pkg::ADDR_CTRL, 32'h00000FFF);
		rdr(ptc_pkg::ADDR_CTRL, d);
		`CHK(d, 32'h00000FFF)
		@(posedge clk);
		run_mode <= 1'b0;
		repeat (3) @(posedge clk);
		run_mode <= 1'b1;
		rdr(ptc_pkg::ADDR_CTRL, d);
		`CHK(d, 32'h0)
		// clock enable low freezes the register port, so this write is lost
		ce <= 1'b0;
		wrr(ptc_pkg::ADDR_CTRL, 32'h0000000F);
		ce <= 1'b1;
		rdr(ptc_pkg::ADDR_CTRL, d);
		`CHK(d, 32'h0)
		summarize();
	end
endmodule // test_pulse_train_homing_control
`default_nettype wire
